// *** design/hfc_flash_host.sv ***
// host controller issuing command sequences to a boot-sector byte flash
// Operation
// - three separate active-low strobes avoid contention
// - commands are plain bus writes to device
// - poll the toggle status bit until two reads match
// - erase may suspend, access others, then resume
`timescale 1ns/100ps
module hfc_flash_host #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 8,
  parameter logic [17:0] UNLOCK_ADDR1 = 18'h00001, // arbitrary, set for the target part
  parameter logic [17:0] UNLOCK_ADDR2 = 18'h00002, // arbitrary
  parameter logic [7:0] UNLOCK_DATA1 = 8'h01, // arbitrary
  parameter logic [7:0] UNLOCK_DATA2 = 8'h02, // arbitrary
  parameter logic [7:0] CMD_PROGRAM = 8'h03, // arbitrary
  parameter logic [7:0] CMD_ERASE_SETUP = 8'h04, // arbitrary
  parameter logic [7:0] CMD_CHIP_ERASE = 8'h05, // arbitrary
  parameter logic [7:0] CMD_SECTOR_ERASE = 8'h06, // arbitrary
  parameter logic [7:0] CMD_SUSPEND = 8'h07, // arbitrary
  parameter logic [7:0] CMD_RESUME = 8'h08 // arbitrary
) (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic arst_n, // async reset
  input wire logic cmd_valid, // user request
  output logic cmd_ready, // request taken when both high
  input wire logic [2:0] cmd_op, // hfc_op_e
  input wire logic [ADDR_W-1:0] cmd_addr, // byte address
  input wire logic [DATA_W-1:0] cmd_wdata, // program data
  input wire logic [6:0] cmd_sect, // sector erase selection
  input wire logic [6:0] prot_mask, // protected sectors
  input wire logic top_boot, // 1 top boot map
  input wire logic vcc_low, // supply too low
  output logic rsp_valid, // answer pulse
  output logic rsp_err, // request refused
  output logic [DATA_W-1:0] rsp_rdata, // read or final status byte
  output logic busy, // operation in progress
  output logic erase_pending, // erase started, not finished
  output logic suspended, // erase on hold
  output logic [ADDR_W-1:0] fl_addr, // flash address
  output logic [DATA_W-1:0] fl_dq_o, // flash data out
  output logic fl_dq_oe, // flash data drive
  input wire logic [DATA_W-1:0] fl_dq_i, // flash data in
  output logic fl_ce_n, // chip select
  output logic fl_we_n, // write strobe
  output logic fl_oe_n, // output drive strobe
  output logic fl_reset_n // flash hardware reset
);

  if (ADDR_W != hfc_pkg::ADDR_W || DATA_W != hfc_pkg::DATA_W) begin : g_chk
    $error("hfc_flash_host: only 18-bit address, 8-bit data supported");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_SEQ = 4'b0001, S_POLL_RD = 4'b0011, S_POLL_CMP = 4'b0010,
    S_READ = 4'b0110, S_SUSP_W = 4'b0111, S_HWRST = 4'b0101, S_RST_W = 4'b0100
  } hfc_state_e;

  localparam int CW = hfc_pkg::CNT_W;

  hfc_state_e st_ff;
  hfc_pkg::hfc_op_e op_ff;
  logic [hfc_pkg::STEP_W-1:0] step_ff;
  logic [hfc_pkg::SECT_W-1:0] sec_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff, tog_ff;
  logic [6:0] sect_ff;
  logic [CW-1:0] cnt_ff;
  logic wait_ff, first_ff, erase_pend_ff, susp_ff;
  logic rsp_valid_ff, rsp_err_ff, rst_n_ff;
  logic [DATA_W-1:0] rsp_rdata_ff;
  logic bc_idle, bc_done;
  logic [DATA_W-1:0] bc_rdata;

  // ==========================================================
  // request decode and refusal checks
  wire hfc_pkg::hfc_op_e req_op = hfc_pkg::hfc_op_e'(cmd_op);
  wire logic [2:0] req_sec = hfc_pkg::hfc_sect_of(cmd_addr, top_boot);
  wire logic req_prot = prot_mask[req_sec];
  wire logic in_erase_sect = erase_pend_ff && sect_ff[req_sec];
  wire logic is_erase = (req_op == hfc_pkg::HFC_OP_CHIP_ERASE) || (req_op == hfc_pkg::HFC_OP_SECT_ERASE);
  wire logic err_prot = ((req_op == hfc_pkg::HFC_OP_PROGRAM) && req_prot) ||
                        ((req_op == hfc_pkg::HFC_OP_CHIP_ERASE) && (prot_mask != 7'h00)) ||
                        ((req_op == hfc_pkg::HFC_OP_SECT_ERASE) && ((cmd_sect & prot_mask) != 7'h00));
  wire logic err_mode = susp_ff ?
    !(req_op == hfc_pkg::HFC_OP_READ || req_op == hfc_pkg::HFC_OP_RESUME || req_op == hfc_pkg::HFC_OP_RESET ||
      (req_op == hfc_pkg::HFC_OP_PROGRAM && !in_erase_sect)) :
    (req_op == hfc_pkg::HFC_OP_SUSPEND || req_op == hfc_pkg::HFC_OP_RESUME ||
     req_op > hfc_pkg::HFC_OP_RESET ||
     (is_erase && erase_pend_ff));
  wire logic err_sel = (req_op == hfc_pkg::HFC_OP_SECT_ERASE) && (cmd_sect == 7'h00);
  wire logic req_err = err_prot || err_mode || err_sel;
  wire logic poll_done = (st_ff == S_POLL_CMP) && !first_ff && (bc_rdata[hfc_pkg::BIT_TOGGLE] ==
                          tog_ff[hfc_pkg::BIT_TOGGLE]);
  wire logic poll_take = (st_ff == S_POLL_CMP) && !poll_done && (op_ff != hfc_pkg::HFC_OP_PROGRAM || !susp_ff) &&
                         erase_pend_ff && !susp_ff &&
                         (req_op == hfc_pkg::HFC_OP_SUSPEND || req_op == hfc_pkg::HFC_OP_RESET);
  assign cmd_ready = !vcc_low && ((st_ff == S_IDLE) || poll_take);
  wire logic fire = cmd_valid && cmd_ready;

  // ==========================================================
  // command sequence table, one bus write per step
  wire logic sect_phase = (op_ff == hfc_pkg::HFC_OP_SECT_ERASE) && (step_ff == 3'h5);
  wire logic single = (op_ff == hfc_pkg::HFC_OP_SUSPEND) || (op_ff == hfc_pkg::HFC_OP_RESUME);
  wire logic last_step = single ? 1'b1 :
                         (op_ff == hfc_pkg::HFC_OP_PROGRAM) ? (step_ff == 3'h3) :
                         (op_ff == hfc_pkg::HFC_OP_CHIP_ERASE) ? (step_ff == 3'h5) :
                         (sec_ff == 3'(hfc_pkg::N_SECT - 1)) && sect_phase;
  wire logic skip = sect_phase && !sect_ff[sec_ff];
  wire logic unlock2 = (step_ff == 3'h1) || (step_ff == 3'h4);
  wire logic [ADDR_W-1:0] seq_addr = single ? addr_ff :
                                     sect_phase ? hfc_pkg::hfc_sect_base(sec_ff, top_boot) :
                                     (op_ff == hfc_pkg::HFC_OP_PROGRAM && step_ff == 3'h3) ? addr_ff :
                                     unlock2 ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
  wire logic [DATA_W-1:0] seq_data = (op_ff == hfc_pkg::HFC_OP_SUSPEND) ? CMD_SUSPEND :
                                     (op_ff == hfc_pkg::HFC_OP_RESUME) ? CMD_RESUME :
                                     sect_phase ? CMD_SECTOR_ERASE :
                                     unlock2 ? UNLOCK_DATA2 :
                                     (step_ff == 3'h0 || step_ff == 3'h3) ?
                                       ((op_ff == hfc_pkg::HFC_OP_PROGRAM && step_ff == 3'h3) ? wdata_ff : UNLOCK_DATA1) :
                                     (step_ff == 3'h5) ? CMD_CHIP_ERASE :
                                     (op_ff == hfc_pkg::HFC_OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
  wire logic seq_adv = (st_ff == S_SEQ) && (skip || (wait_ff && bc_done));
  wire logic bc_start = !wait_ff && bc_idle && (((st_ff == S_SEQ) && !skip) || (st_ff == S_POLL_RD) ||
                        (st_ff == S_READ));
  wire logic bc_wr = (st_ff == S_SEQ);
  wire logic [ADDR_W-1:0] bc_addr = (st_ff == S_SEQ) ? seq_addr : addr_ff;
  wire logic cnt_end = (cnt_ff == '0);
  wire logic erase_op = (op_ff == hfc_pkg::HFC_OP_CHIP_ERASE) || (op_ff == hfc_pkg::HFC_OP_SECT_ERASE) ||
                        (op_ff == hfc_pkg::HFC_OP_RESUME);

  // ==========================================================
  // main sequencer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= S_IDLE;
      op_ff <= hfc_pkg::HFC_OP_READ;
      step_ff <= '0;
      sec_ff <= '0;
      addr_ff <= hfc_pkg::RST_ADDR;
      wdata_ff <= hfc_pkg::RST_DATA;
      sect_ff <= 7'h00;
      tog_ff <= hfc_pkg::RST_DATA;
      cnt_ff <= '0;
      wait_ff <= 1'b0;
      first_ff <= 1'b1;
      erase_pend_ff <= 1'b0;
      susp_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_err_ff <= 1'b0;
      rsp_rdata_ff <= hfc_pkg::RST_DATA;
      rst_n_ff <= hfc_pkg::RST_STROBE_N;
    end else begin
      rsp_valid_ff <= 1'b0;
      if (bc_start) begin
        wait_ff <= 1'b1;
      end else if (bc_done) begin
        wait_ff <= 1'b0;
      end
      case (st_ff)
        S_IDLE: if (fire) begin
          rsp_err_ff <= req_err;
          if (req_err) begin
            rsp_valid_ff <= 1'b1;
          end else begin
            op_ff <= req_op;
            addr_ff <= cmd_addr;
            wdata_ff <= cmd_wdata;
            step_ff <= '0;
            sec_ff <= '0;
            first_ff <= 1'b1;
            if (is_erase) begin
              sect_ff <= (req_op == hfc_pkg::HFC_OP_CHIP_ERASE) ? 7'h7f : cmd_sect; // chip erase covers every sector
            end
            if (req_op == hfc_pkg::HFC_OP_READ) begin
              st_ff <= S_READ;
            end else if (req_op == hfc_pkg::HFC_OP_RESET) begin
              st_ff <= S_HWRST;
              cnt_ff <= CW'(hfc_pkg::RST_PULSE_CYC - 1);
              rst_n_ff <= 1'b0;
            end else begin
              st_ff <= S_SEQ;
            end
          end
        end
        S_SEQ: if (seq_adv) begin
          if (last_step) begin
            if (op_ff == hfc_pkg::HFC_OP_SUSPEND) begin
              st_ff <= S_SUSP_W;
              cnt_ff <= CW'(hfc_pkg::SUSPEND_CYC - 1);
            end else begin
              st_ff <= S_POLL_RD;
              if (erase_op) begin
                erase_pend_ff <= 1'b1;
                susp_ff <= 1'b0;
              end
            end
          end else if (sect_phase) begin
            sec_ff <= sec_ff + 1'b1;
          end else begin
            step_ff <= step_ff + 1'b1;
          end
        end
        S_POLL_RD: if (wait_ff && bc_done) begin
          st_ff <= S_POLL_CMP;
        end
        S_POLL_CMP: if (poll_done) begin
          st_ff <= S_IDLE;
          rsp_valid_ff <= 1'b1;
          rsp_err_ff <= 1'b0;
          rsp_rdata_ff <= bc_rdata;
          if (erase_op) begin
            erase_pend_ff <= 1'b0;
          end
        end else if (fire && req_op == hfc_pkg::HFC_OP_RESET) begin
          st_ff <= S_HWRST;
          cnt_ff <= CW'(hfc_pkg::RST_PULSE_CYC - 1);
          rst_n_ff <= 1'b0;
        end else if (fire) begin
          st_ff <= S_SEQ;
          op_ff <= hfc_pkg::HFC_OP_SUSPEND;
          step_ff <= '0;
        end else begin
          tog_ff <= bc_rdata;
          first_ff <= 1'b0;
          st_ff <= S_POLL_RD;
        end
        S_READ: if (wait_ff && bc_done) begin
          st_ff <= S_IDLE;
          rsp_valid_ff <= 1'b1;
          rsp_rdata_ff <= bc_rdata;
        end
        S_SUSP_W: if (cnt_end) begin
          st_ff <= S_IDLE;
          susp_ff <= 1'b1;
          rsp_valid_ff <= 1'b1;
          rsp_err_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
        S_HWRST: if (cnt_end) begin
          st_ff <= S_RST_W;
          rst_n_ff <= 1'b1;
          cnt_ff <= CW'(hfc_pkg::RST_READY_CYC - 1);
          erase_pend_ff <= 1'b0;
          susp_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
        default: if (cnt_end) begin
          st_ff <= S_IDLE;
          rsp_valid_ff <= 1'b1;
          rsp_err_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // flash bus cycle engine
  hfc_bus_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .SETUP_CYC(hfc_pkg::SETUP_CYC),
    .STROBE_CYC(hfc_pkg::STROBE_CYC),
    .RECOV_CYC(hfc_pkg::RECOV_CYC)
  ) u_bus (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(bc_start),
    .wr(bc_wr),
    .addr(bc_addr),
    .wdata(seq_data),
    .idle(bc_idle),
    .done(bc_done),
    .rdata(bc_rdata),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );

  assign rsp_valid = rsp_valid_ff;
  assign rsp_err = rsp_err_ff;
  assign rsp_rdata = rsp_rdata_ff;
  assign busy = (st_ff != S_IDLE);
  assign erase_pending = erase_pend_ff;
  assign suspended = susp_ff;
  assign fl_reset_n = rst_n_ff;

endmodule

// *** design/hfc_pkg.sv ***
// shared constants, timing and sector map for the boot-sector flash host controller
package hfc_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int ARRAY_BYTES = 262144;
  localparam int N_SECT = 7;
  localparam int SECT_W = 3;
  localparam int STEP_W = 3;
  localparam int BIT_POLL = 7;
  localparam int BIT_TOGGLE = 6;

  // ==========================================================
  // timing, in ns, and derived cycle counts
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_SETUP_NS = 40;
  localparam int T_STROBE_NS = 80;
  localparam int T_RECOV_NS = 40;
  localparam int T_RST_PULSE_NS = 500;
  localparam int T_RST_READY_NS = 1000;
  localparam int T_SUSPEND_NS = 20000;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_CYC = (T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_PULSE_CYC = (T_RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_READY_CYC = (T_RST_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUSPEND_CYC = (T_SUSPEND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;

  // ==========================================================
  // values after reset
  localparam logic RST_STROBE_N = 1'b1;
  localparam logic [ADDR_W-1:0] RST_ADDR = 18'h00000;
  localparam logic [DATA_W-1:0] RST_DATA = 8'h00;

  // ==========================================================
  // user operations
  typedef enum logic [2:0] {
    HFC_OP_READ = 3'h0,
    HFC_OP_PROGRAM = 3'h1,
    HFC_OP_CHIP_ERASE = 3'h2,
    HFC_OP_SECT_ERASE = 3'h3,
    HFC_OP_SUSPEND = 3'h4,
    HFC_OP_RESUME = 3'h5,
    HFC_OP_RESET = 3'h6
  } hfc_op_e;

  // ==========================================================
  // sector map, bottom and top boot
  localparam logic [ADDR_W-1:0] SECT_BASE_BOT [N_SECT] = '{
    18'h00000, 18'h04000, 18'h06000, 18'h08000, 18'h10000, 18'h20000, 18'h30000};
  localparam logic [ADDR_W-1:0] SECT_BASE_TOP [N_SECT] = '{
    18'h00000, 18'h10000, 18'h20000, 18'h30000, 18'h38000, 18'h3a000, 18'h3c000};

  function automatic logic [ADDR_W-1:0] hfc_sect_base(input logic [SECT_W-1:0] idx, input logic top);
    logic [ADDR_W-1:0] b;
    b = top ? SECT_BASE_TOP[idx] : SECT_BASE_BOT[idx];
    return b;
  endfunction

  function automatic logic [SECT_W-1:0] hfc_sect_of(input logic [ADDR_W-1:0] a, input logic top);
    logic [SECT_W-1:0] s;
    s = 3'h0;
    for (int i = 0; i < N_SECT; i++) begin
      if (a >= hfc_sect_base(SECT_W'(i), top)) begin
        s = SECT_W'(i);
      end
    end
    return s;
  endfunction

endpackage

// *** design/hfc_bus_cycle.sv ***
// one asynchronous flash bus cycle: address setup, strobe, recovery
`timescale 1ns/100ps
module hfc_bus_cycle #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 8,
  parameter int SETUP_CYC = 1,
  parameter int STROBE_CYC = 2,
  parameter int RECOV_CYC = 1
) (
  input wire logic ref_clk, // system clock
  input wire logic arst_n, // async reset
  input wire logic start, // begin a cycle, only when idle
  input wire logic wr, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] addr, // cycle address
  input wire logic [DATA_W-1:0] wdata, // write data
  output logic idle, // engine free
  output logic done, // cycle finished pulse
  output logic [DATA_W-1:0] rdata, // sampled read data
  output logic [ADDR_W-1:0] fl_addr, // flash address pins
  output logic [DATA_W-1:0] fl_dq_o, // flash data out
  output logic fl_dq_oe, // flash data drive enable
  input wire logic [DATA_W-1:0] fl_dq_i, // flash data in
  output logic fl_ce_n, // chip select
  output logic fl_we_n, // write strobe
  output logic fl_oe_n // output drive strobe
);

  typedef enum logic [1:0] {BC_IDLE = 2'b00, BC_SETUP = 2'b01, BC_STROBE = 2'b11, BC_RECOV = 2'b10} hfc_bc_e;

  localparam int CW = 4;

  if (SETUP_CYC < 1 || STROBE_CYC < 1 || RECOV_CYC < 1 || STROBE_CYC > 15 || SETUP_CYC > 15 || RECOV_CYC > 15)
  begin : g_chk
    $error("hfc_bus_cycle: phase lengths must be 1..15");
  end

  hfc_bc_e st_ff, nxt_st;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic wr_ff;
  logic ce_n_ff, we_n_ff, oe_n_ff, oe_ff, done_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff, rdata_ff;

  wire logic phase_end = (cnt_ff == '0);
  wire logic sample_rd = (st_ff == BC_STROBE) && phase_end && !wr_ff;

  // ==========================================================
  // phase sequencing
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      BC_IDLE: if (start) begin
        nxt_st = BC_SETUP;
        nxt_cnt = CW'(SETUP_CYC - 1);
      end
      BC_SETUP: if (phase_end) begin
        nxt_st = BC_STROBE;
        nxt_cnt = CW'(STROBE_CYC - 1);
      end else begin
        nxt_cnt = cnt_ff - 1'b1;
      end
      BC_STROBE: if (phase_end) begin
        nxt_st = BC_RECOV;
        nxt_cnt = CW'(RECOV_CYC - 1);
      end else begin
        nxt_cnt = cnt_ff - 1'b1;
      end
      default: if (phase_end) begin
        nxt_st = BC_IDLE;
      end else begin
        nxt_cnt = cnt_ff - 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= BC_IDLE;
      cnt_ff <= '0;
      wr_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      done_ff <= 1'b0;
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      oe_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      done_ff <= (st_ff == BC_RECOV) && phase_end;
      if (st_ff == BC_IDLE && start) begin
        wr_ff <= wr;
        addr_ff <= addr;
        wdata_ff <= wdata;
      end
      if (sample_rd) begin
        rdata_ff <= fl_dq_i;
      end
      // separate strobes keep the data bus free of contention
      ce_n_ff <= (nxt_st == BC_IDLE);
      we_n_ff <= !((nxt_st == BC_STROBE) && (st_ff == BC_IDLE ? wr : wr_ff));
      oe_n_ff <= !((nxt_st == BC_STROBE) && !(st_ff == BC_IDLE ? wr : wr_ff));
      oe_ff <= (nxt_st != BC_IDLE) && (st_ff == BC_IDLE ? wr : wr_ff);
    end
  end

  assign idle = (st_ff == BC_IDLE);
  assign done = done_ff;
  assign rdata = rdata_ff;
  assign fl_addr = addr_ff;
  assign fl_dq_o = wdata_ff;
  assign fl_dq_oe = oe_ff;
  assign fl_ce_n = ce_n_ff;
  assign fl_we_n = we_n_ff;
  assign fl_oe_n = oe_n_ff;

endmodule

// *** verification/hfc_flash_model.sv ***
// behavioural byte flash device answering the host controller pins
`timescale 1ns/100ps
module hfc_flash_model #(
  parameter int BUSY_RD = 6
) (
  input wire logic [17:0] fl_addr, // address
  input wire logic [7:0] fl_dq_o, // data in
  input wire logic fl_dq_oe, // host drives
  output logic [7:0] fl_dq_i, // data out
  input wire logic fl_ce_n, // chip select
  input wire logic fl_we_n, // write strobe
  input wire logic fl_oe_n, // output strobe
  input wire logic fl_reset_n // hardware reset
);
  logic [7:0] mem [int];
  logic [7:0] last_ff = 8'h00;
  logic [7:0] last_rd_ff = 8'h00;
  logic tog_ff = 1'b0;
  logic susp_ff = 1'b0;
  int busy_ff = 0;
  function automatic logic [7:0] arr(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  wire busy_rd = busy_ff > 0 && !susp_ff;
  wire [7:0] cur = fl_oe_n ? 8'h00 : arr(fl_addr);
  // released bus shows the inverse of the last byte
  assign fl_dq_i = (fl_ce_n || fl_oe_n) ? ~last_rd_ff : busy_rd ? {~cur[7], tog_ff, cur[5:0]} : cur;
  always @(fl_dq_i) if (!fl_ce_n && !fl_oe_n) last_rd_ff = fl_dq_i;
  always @(posedge fl_oe_n) if (!fl_ce_n && busy_rd) begin
    tog_ff = ~tog_ff;
    busy_ff--;
  end
  always @(negedge fl_reset_n) begin
    busy_ff = 0;
    susp_ff = 1'b0;
  end
  always @(posedge fl_we_n) if (!fl_ce_n && fl_reset_n) begin
    if (busy_ff > 0 && fl_dq_o == 8'h07) susp_ff = 1'b1;
    else if (susp_ff && fl_dq_o == 8'h08) susp_ff = 1'b0;
    else if (last_ff == 8'h03) begin
      mem[fl_addr] = fl_dq_o;
      busy_ff = BUSY_RD;
    end else if (fl_dq_o == 8'h05) begin
      mem.delete();
      busy_ff = 4 * BUSY_RD;
    end else if (fl_dq_o == 8'h06) begin
      erase_sect(fl_addr);
      busy_ff = 4 * BUSY_RD;
    end
    last_ff = fl_dq_o;
  end
  task automatic erase_sect(input logic [17:0] b);
    int nxt;
    int q[$];
    nxt = hfc_pkg::ARRAY_BYTES;
    for (int i = 0; i < hfc_pkg::N_SECT; i++) if (hfc_pkg::SECT_BASE_BOT[i] > b && hfc_pkg::SECT_BASE_BOT[i] < nxt)
      nxt = int'(hfc_pkg::SECT_BASE_BOT[i]);
    foreach (mem[k]) if (k >= b && k < nxt) q.push_back(k);
    foreach (q[j]) mem.delete(q[j]);
  endtask
endmodule

// *** verification/hfc_flash_host_properties.sv ***
// pin and handshake assertions for the flash host controller
`timescale 1ns/100ps
module hfc_flash_host_properties (
  input wire logic ref_clk, // clock
  input wire logic arst_n, // reset
  input wire logic cmd_valid, // request
  input wire logic cmd_ready, // taken
  input wire logic [2:0] cmd_op, // op
  input wire logic vcc_low, // low supply
  input wire logic rsp_valid, // answer
  input wire logic rsp_err, // refused
  input wire logic busy, // running
  input wire logic erase_pending, // erase open
  input wire logic suspended, // erase held
  input wire logic [17:0] fl_addr, // address
  input wire logic [7:0] fl_dq_o, // data out
  input wire logic fl_dq_oe, // drive
  input wire logic fl_ce_n, // chip select
  input wire logic fl_we_n, // write strobe
  input wire logic fl_oe_n, // output strobe
  input wire logic fl_reset_n // flash reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_we_pulse;
    !fl_we_n ##1 !fl_we_n ##1 fl_we_n;
  endsequence
  a_strobe_excl: assert property (fl_oe_n || fl_we_n) else $error("oe and we low together");
  a_strobe_sel: assert property (!(fl_oe_n && fl_we_n) |-> !fl_ce_n) else $error("strobe without select");
  a_no_contend: assert property (!fl_oe_n |-> !fl_dq_oe) else $error("host drives during read");
  a_we_width: assert property ($fell(fl_we_n) |-> s_we_pulse) else $error("write pulse width");
  a_write_hold: assert property ($fell(fl_we_n) |=> $stable(fl_addr) && $stable(fl_dq_o) && fl_dq_oe)
    else $error("write data moved");
  a_vcc_block: assert property (vcc_low |-> !cmd_ready) else $error("request ready at low supply");
  a_poll_ops: assert property (cmd_valid && cmd_ready && busy && !suspended |-> cmd_op == 3'h4 || cmd_op == 3'h6)
    else $error("command taken while running");
  a_susp_erase: assert property (suspended |-> erase_pending) else $error("suspend without erase");
  a_rst_pulse: assert property ($fell(fl_reset_n) |-> !fl_reset_n [*8]) else $error("reset pulse short");
  a_refuse_quiet: assert property (rsp_valid && rsp_err |-> fl_ce_n && $past(fl_ce_n))
    else $error("refused with bus activity");
endmodule
bind hfc_flash_host hfc_flash_host_properties u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .vcc_low(vcc_low), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .busy(busy),
  .erase_pending(erase_pending), .suspended(suspended), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
  .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n));

// *** verification/hfc_flash_host_tb_top.sv ***
// self-checking bench for the flash host controller with a device model
`timescale 1ns/100ps
module hfc_flash_host_tb_top;
  logic ref_clk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, vcc_low = 1'b0, top_boot = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [17:0] cmd_addr = 18'h00000;
  logic [7:0] cmd_wdata = 8'h00;
  logic [6:0] cmd_sect = 7'h00, prot_mask = 7'h00;
  logic cmd_ready, rsp_valid, rsp_err, busy, erase_pending, suspended, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n;
  logic [7:0] rsp_rdata, fl_dq_o, fl_dq_i;
  logic [17:0] fl_addr;
  int mismatches = 0, cmp_count = 0;
  always #20 ref_clk = ~ref_clk;
  hfc_flash_host uut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_sect(cmd_sect), .prot_mask(prot_mask), .top_boot(top_boot),
    .vcc_low(vcc_low), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .busy(busy),
    .erase_pending(erase_pending), .suspended(suspended), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n));
  hfc_flash_model u_flash (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hang(input string nm);
    mismatches++;
    $display("mismatch %s expected done seen timeout", nm);
    close_out();
  endtask
  // hold the request until taken, then optionally wait for its answer
  task automatic send(input logic [2:0] op, input logic [17:0] a, input logic [7:0] d, input logic [6:0] s, input bit w);
    int n;
    n = 0;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_sect = s;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) begin
      @(negedge ref_clk);
      if (++n > 3000) hang("cmd_ready");
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (w && rsp_valid !== 1'b1) begin
      @(negedge ref_clk);
      if (++n > 3000) hang("rsp_valid");
    end
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] exp);
    send(3'h0, a, 8'h00, 7'h00, 1'b1);
    chk("rsp_rdata", exp, rsp_rdata);
  endtask
  task automatic t_program();
    send(3'h1, 18'h10005, 8'h5a, 7'h00, 1'b1);
    chk("rsp_err", 8'h00, {7'h00, rsp_err});
    chk("rsp_rdata", 8'h5a, rsp_rdata);
    send(3'h1, 18'h00010, 8'ha5, 7'h00, 1'b1);
    rd(18'h10005, 8'h5a);
    rd(18'h20000, 8'hff);
    $display("t_program done");
  endtask
  task automatic t_protect();
    logic [2:0] ops [4] = '{3'h1, 3'h2, 3'h3, 3'h3};
    logic [6:0] sel [4] = '{7'h00, 7'h00, 7'h10, 7'h00};
    prot_mask = 7'h10;
    for (int i = 0; i < 4; i++) begin
      send(ops[i], 18'h10006, 8'h11, sel[i], 1'b1);
      chk("rsp_err", 8'h01, {7'h00, rsp_err});
    end
    top_boot = 1'b1;
    prot_mask = 7'h02;
    send(3'h1, 18'h10006, 8'h11, 7'h00, 1'b1);
    chk("rsp_err", 8'h01, {7'h00, rsp_err});
    top_boot = 1'b0;
    prot_mask = 7'h00;
    rd(18'h10006, 8'hff);
    $display("t_protect done");
  endtask
  task automatic t_suspend();
    int n;
    send(3'h5, 18'h10000, 8'h00, 7'h00, 1'b1);
    chk("rsp_err", 8'h01, {7'h00, rsp_err});
    send(3'h3, 18'h00000, 8'h00, 7'h10, 1'b0);
    send(3'h4, 18'h10000, 8'h00, 7'h00, 1'b1);
    chk("suspended", 8'h01, {7'h00, suspended});
    rd(18'h00010, 8'ha5);
    send(3'h1, 18'h10001, 8'h00, 7'h00, 1'b1);
    chk("rsp_err", 8'h01, {7'h00, rsp_err});
    send(3'h5, 18'h10000, 8'h00, 7'h00, 1'b1);
    chk("rsp_err", 8'h00, {7'h00, rsp_err});
    n = 0;
    while (erase_pending !== 1'b0) begin
      @(negedge ref_clk);
      if (++n > 5000) hang("erase_pending");
    end
    rd(18'h10005, 8'hff);
    rd(18'h00010, 8'ha5);
    $display("t_suspend done");
  endtask
  task automatic t_reset();
    send(3'h7, 18'h00000, 8'h00, 7'h00, 1'b1);
    chk("rsp_err", 8'h01, {7'h00, rsp_err});
    send(3'h2, 18'h00000, 8'h00, 7'h00, 1'b0);
    send(3'h6, 18'h00000, 8'h00, 7'h00, 1'b1);
    chk("erase_pending", 8'h00, {7'h00, erase_pending});
    rd(18'h00010, 8'hff);
    $display("t_reset done");
  endtask
  task automatic t_vcc();
    vcc_low = 1'b1;
    repeat (20) begin
      @(negedge ref_clk);
      chk("cmd_ready", 8'h00, {7'h00, cmd_ready});
    end
    vcc_low = 1'b0;
    rd(18'h00020, 8'hff);
    $display("t_vcc done");
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    @(negedge ref_clk);
    t_program();
    t_protect();
    t_suspend();
    t_reset();
    t_vcc();
    close_out();
  end
endmodule
